// ---- common/hcfl_pkg.sv ----
package hcfl_pkg;
    // clock rate
    localparam int unsigned CLK_HZ = 125_000_000;
    // overcurrent hold time, milliseconds
    localparam int unsigned OC_HOLD_MS = 15;
    // overcurrent hold in clock cycles (longest time, rounds down)
    localparam int unsigned OC_HOLD_CYC = (CLK_HZ / 1000) * OC_HOLD_MS;
    // startup threshold on hall frequency, millihertz
    localparam int unsigned SINE_MIN_MHZ = 1000;
    // longest hall edge period that still counts as 1.0 Hz or more
    localparam int unsigned SINE_PERIOD_CYC = (CLK_HZ / SINE_MIN_MHZ) * 1000;
    // advance step in units of 1/16 degree (0.9375 deg = 15/16)
    localparam logic [7:0] ADV_STEP_Q4 = 8'h0F;
    // hall cycles between advance steps
    localparam logic [2:0] ADV_HALL_CYCLES = 3'h4;
    // advance angle reset value
    localparam logic [7:0] ADV_RESET = 8'h00;
    // register offsets
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_MASK = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_ADV = 8'h0C;
    // status and mask bit positions
    localparam int unsigned EV_FAULT = 0;
    localparam int unsigned EV_HALL_BAD = 1;
    localparam int unsigned EV_OVERCURRENT = 2;
    localparam int unsigned EV_REVERSE = 3;
    localparam int unsigned EV_WIDTH = 4;
    // control bit positions and reset values
    localparam int unsigned CTRL_ADV_EN = 0;
    localparam int unsigned CTRL_TEST = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam logic [EV_WIDTH-1:0] MASK_RESET = 4'h0;
    // drive mode
    typedef enum logic [0:0] {
        DRIVE_TRAP = 1'b0,
        DRIVE_SINE = 1'b1
    } hcfl_drive_type;
endpackage

// ---- common/hcfl_sync_if.sv ----
`timescale 1ns/10ps
// raw asynchronous flags in, filtered levels out
interface hcfl_sync_if #(parameter int W = 10);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport owner (input clean, output raw);
    modport filter (input raw, output clean);
endinterface

// ---- core/hcfl_sync.sv ----
`timescale 1ns/10ps
// three-stage synchroniser; a change counts once stages two and three agree
module hcfl_sync #(
    parameter int W = 10
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // flag carrier
    hcfl_sync_if.filter sif
);
    logic [W-1:0] s1_ff; // first stage, read only by s2
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] clean_ff;

    // shift chain
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= sif.raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // per bit: take the new level only when stages agree
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    clean_ff[gi] <= 1'b0;
                end else if (s2_ff[gi] == s3_ff[gi]) begin
                    clean_ff[gi] <= s3_ff[gi];
                end
            end
        end
    endgenerate

    assign sif.clean = clean_ff;
endmodule

// ---- core/hcfl_top.sv ----
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
// How it works
// RQ1: target advance taken from digitized level input
// RQ2: step advance 0.9375 deg per four hall cycles
// RQ3: forward hall table drives six switches
// RQ4: reverse hall table drives six switches
// RQ5: fault output is OR of six protections
// RQ6: overcurrent holds fault for 15 ms
// RQ7: host stops inputs within overcurrent hold
// RQ8: reference lockout forces all switches off
// RQ9: reference lockout release resumes hall switching
// RQ10: bootstrap lockout forces high sides off
// RQ11: bootstrap release lets high sides follow
// RQ12: supply lockout forces all switches off
// RQ13: supply release resumes hall switching
// RQ14: trapezoidal below 1 Hz, sinusoidal above
// RQ15: reverse rotation forces trapezoidal within 60 deg
// RQ16: all-equal hall inputs flag fault, switches off
// RQ17: test mode pins advance at zero
// RQ18: flags synchronised, switch commands registered
// RQ19: never both switches of one phase
module hcfl_top #(
    parameter int unsigned OC_HOLD_CYCLES = hcfl_pkg::OC_HOLD_CYC,
    parameter int unsigned SINE_PERIOD_CYCLES = hcfl_pkg::SINE_PERIOD_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // hall position inputs
    input wire logic hall_u,
    input wire logic hall_v,
    input wire logic hall_w,
    // digitized supply comparators, high when at or below lower threshold
    input wire logic reference_undervoltage_lockout,
    input wire logic supply_undervoltage_lockout,
    input wire logic [2:0] bootstrap_undervoltage_lockout,
    // other protection flags
    input wire logic overcurrent_shutdown,
    input wire logic thermal_shutdown,
    input wire logic motor_lock_guard,
    // settings
    input wire logic direction_select,
    input wire logic [7:0] advance_level_input,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // switch commands, u v w
    output logic [2:0] high_side_on,
    output logic [2:0] low_side_on,
    // fault, interrupt and drive mode
    output logic fault_out,
    output logic irq,
    output logic sine_drive
);
    localparam int NS = 10;

    // synchronised flags
    hcfl_sync_if #(.W(NS)) sif ();
    assign sif.raw = {direction_select, motor_lock_guard, thermal_shutdown,
                      overcurrent_shutdown, bootstrap_undervoltage_lockout,
                      supply_undervoltage_lockout, reference_undervoltage_lockout,
                      1'b0}; // see RQ18
    hcfl_sync #(.W(NS)) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .sif(sif)
    );
    logic ref_uv, vcc_uv, oc_s, tsd_s, mlp_s, dir_fwd;
    logic [2:0] vb_uv;
    assign ref_uv = sif.clean[1];
    assign vcc_uv = sif.clean[2];
    assign vb_uv = sif.clean[5:3];
    assign oc_s = sif.clean[6];
    assign tsd_s = sif.clean[7];
    assign mlp_s = sif.clean[8];
    assign dir_fwd = sif.clean[9];

    // hall inputs get their own three-stage filter
    logic [2:0] h1_ff, h2_ff, h3_ff, hall_ff, hall_prev_ff;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            h1_ff <= 3'h0;
            h2_ff <= 3'h0;
            h3_ff <= 3'h0;
            hall_ff <= 3'h0;
            hall_prev_ff <= 3'h0;
        end else begin
            h1_ff <= {hall_u, hall_v, hall_w};
            h2_ff <= h1_ff;
            h3_ff <= h2_ff;
            if (h2_ff == h3_ff) begin
                hall_ff <= h3_ff;
            end
            hall_prev_ff <= hall_ff;
        end
    end
    logic hall_bad, hall_edge, hall_cycle;
    assign hall_bad = (hall_ff == 3'h0) || (hall_ff == 3'h7); // see RQ16
    assign hall_edge = hall_ff != hall_prev_ff;
    // one hall cycle: rising edge of hall_u
    assign hall_cycle = hall_ff[2] && !hall_prev_ff[2];

    // expected successor of previous state in forward order
    function automatic logic [2:0] fwd_next(input logic [2:0] s);
        case (s)
            3'h5: fwd_next = 3'h4;
            3'h4: fwd_next = 3'h6;
            3'h6: fwd_next = 3'h2;
            3'h2: fwd_next = 3'h3;
            3'h3: fwd_next = 3'h1;
            3'h1: fwd_next = 3'h5;
            default: fwd_next = 3'h0;
        endcase
    endfunction

    // reverse rotation: judged at each valid hall step, so before 60 deg
    logic reverse_ff;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            reverse_ff <= 1'b0;
        end else if (hall_edge && !hall_bad && hall_prev_ff != 3'h0
                     && hall_prev_ff != 3'h7) begin
            // forward order matches the forward table when direction high
            reverse_ff <= (fwd_next(hall_prev_ff) == hall_ff) != dir_fwd; // see RQ15
        end
    end

    // hall period timer for startup mode choice
    logic [31:0] period_ff;
    hcfl_pkg::hcfl_drive_type drive_ff;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            period_ff <= SINE_PERIOD_CYCLES; // no edge seen yet counts as slow
        end else if (hall_edge) begin
            period_ff <= 32'h0;
        end else if (period_ff < SINE_PERIOD_CYCLES) begin
            period_ff <= period_ff + 32'h1;
        end
    end
    // slow or reversed motion falls back to trapezoidal at once
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            drive_ff <= hcfl_pkg::DRIVE_TRAP;
        end else begin
            case (drive_ff)
                hcfl_pkg::DRIVE_TRAP: begin
                    if (hall_cycle && period_ff < SINE_PERIOD_CYCLES && !reverse_ff) begin
                        drive_ff <= hcfl_pkg::DRIVE_SINE; // see RQ14
                    end
                end
                hcfl_pkg::DRIVE_SINE: begin
                    if (reverse_ff || period_ff >= SINE_PERIOD_CYCLES) begin
                        drive_ff <= hcfl_pkg::DRIVE_TRAP; // see RQ14 see RQ15
                    end
                end
                default: drive_ff <= hcfl_pkg::DRIVE_TRAP;
            endcase
        end
    end

    // overcurrent hold counter; host must quiet its inputs meanwhile
    logic [31:0] oc_cnt_ff;
    logic oc_prev_ff;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            oc_cnt_ff <= 32'h0;
            oc_prev_ff <= 1'b0;
        end else begin
            oc_prev_ff <= oc_s;
            if (oc_s && !oc_prev_ff) begin
                oc_cnt_ff <= OC_HOLD_CYCLES; // see RQ6 see RQ7
            end else if (oc_cnt_ff != 32'h0) begin
                oc_cnt_ff <= oc_cnt_ff - 32'h1;
            end
        end
    end
    logic oc_active;
    assign oc_active = oc_s || (oc_cnt_ff != 32'h0);

    // registers
    logic [1:0] ctrl_ff;
    logic [hcfl_pkg::EV_WIDTH-1:0] mask_ff, status_ff;
    logic [7:0] adv_ff;
    logic wr_en, rd_en;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    // fault combination
    logic fault_any;
    assign fault_any = ref_uv || oc_active || tsd_s || mlp_s
                       || reverse_ff || hall_bad; // see RQ5

    // all-off conditions; bootstrap lockout only gates its high side
    logic all_off;
    assign all_off = ref_uv || vcc_uv || oc_active || tsd_s || mlp_s
                     || hall_bad; // see RQ8 see RQ9 see RQ12 see RQ13

    // trapezoidal lookup, {uh,ul,vh,vl,wh,wl}
    logic [5:0] trap_sw;
    always_comb begin
        trap_sw = 6'h00;
        if (dir_fwd) begin
            case (hall_ff) // see RQ3
                3'h5: trap_sw = 6'h18;
                3'h4: trap_sw = 6'h12;
                3'h6: trap_sw = 6'h06;
                3'h2: trap_sw = 6'h24;
                3'h3: trap_sw = 6'h21;
                3'h1: trap_sw = 6'h09;
                default: trap_sw = 6'h00;
            endcase
        end else begin
            case (hall_ff) // see RQ4
                3'h2: trap_sw = 6'h18;
                3'h3: trap_sw = 6'h12;
                3'h1: trap_sw = 6'h06;
                3'h5: trap_sw = 6'h24;
                3'h4: trap_sw = 6'h21;
                3'h6: trap_sw = 6'h09;
                default: trap_sw = 6'h00;
            endcase
        end
    end

    // registered switch commands with gating and shoot-through guard
    logic [2:0] nxt_hs, nxt_ls, hs_ff, ls_ff;
    always_comb begin
        nxt_hs = {trap_sw[5], trap_sw[3], trap_sw[1]};
        nxt_ls = {trap_sw[4], trap_sw[2], trap_sw[0]};
        if (all_off) begin
            nxt_hs = 3'h0;
            nxt_ls = 3'h0;
        end
        // vb_uv is per phase u v w, matching bit order
        nxt_hs = nxt_hs & ~vb_uv; // see RQ10 see RQ11
        nxt_ls = nxt_ls & ~nxt_hs; // see RQ19
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            hs_ff <= 3'h0;
            ls_ff <= 3'h0;
        end else begin
            hs_ff <= nxt_hs; // see RQ18
            ls_ff <= nxt_ls;
        end
    end
    assign high_side_on = hs_ff;
    assign low_side_on = ls_ff;

    // fault output register
    logic fault_ff;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            fault_ff <= 1'b0;
        end else begin
            fault_ff <= fault_any; // see RQ5 see RQ6
        end
    end
    assign fault_out = fault_ff;
    assign sine_drive = drive_ff == hcfl_pkg::DRIVE_SINE;

    // phase advance: target from level input in 1/16 degree, step per four cycles
    logic [2:0] cyc_cnt_ff;
    logic [7:0] target;
    assign target = ctrl_ff[hcfl_pkg::CTRL_TEST] ? 8'h00 : advance_level_input; // see RQ1 see RQ17
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cyc_cnt_ff <= 3'h0;
            adv_ff <= hcfl_pkg::ADV_RESET;
        end else if (ctrl_ff[hcfl_pkg::CTRL_TEST]) begin
            cyc_cnt_ff <= 3'h0;
            adv_ff <= 8'h00; // see RQ17
        end else if (ctrl_ff[hcfl_pkg::CTRL_ADV_EN] && hall_cycle) begin
            if (cyc_cnt_ff == hcfl_pkg::ADV_HALL_CYCLES - 3'h1) begin
                cyc_cnt_ff <= 3'h0;
                // step toward target; short remainder lands exactly
                if (adv_ff + hcfl_pkg::ADV_STEP_Q4 <= target
                    && adv_ff <= 8'hFF - hcfl_pkg::ADV_STEP_Q4) begin
                    adv_ff <= adv_ff + hcfl_pkg::ADV_STEP_Q4; // see RQ2
                end else if (adv_ff >= target + hcfl_pkg::ADV_STEP_Q4
                             && target <= 8'hFF - hcfl_pkg::ADV_STEP_Q4) begin
                    adv_ff <= adv_ff - hcfl_pkg::ADV_STEP_Q4; // see RQ2
                end else begin
                    adv_ff <= target;
                end
            end else begin
                cyc_cnt_ff <= cyc_cnt_ff + 3'h1;
            end
        end
    end

    // control and mask writes
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_ff <= hcfl_pkg::CTRL_RESET;
            mask_ff <= hcfl_pkg::MASK_RESET;
        end else if (wr_en) begin
            if (paddr == hcfl_pkg::OFF_CTRL) begin
                ctrl_ff <= pwdata[1:0];
            end
            if (paddr == hcfl_pkg::OFF_MASK) begin
                mask_ff <= pwdata[hcfl_pkg::EV_WIDTH-1:0];
            end
        end
    end

    // sticky events; a new event wins over a write-one clear
    logic [hcfl_pkg::EV_WIDTH-1:0] ev, clr;
    assign ev = {reverse_ff, oc_s && !oc_prev_ff, hall_bad, fault_any && !fault_ff};
    assign clr = (wr_en && paddr == hcfl_pkg::OFF_STATUS) ?
                 pwdata[hcfl_pkg::EV_WIDTH-1:0] : '0;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            status_ff <= '0;
        end else begin
            status_ff <= (status_ff & ~clr) | ev;
        end
    end
    assign irq = |(status_ff & mask_ff);

    // read data registered in the setup phase; zero-wait slave
    logic [31:0] rdata_ff;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_ff <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                hcfl_pkg::OFF_STATUS: rdata_ff <= {28'h0, status_ff};
                hcfl_pkg::OFF_MASK: rdata_ff <= {28'h0, mask_ff};
                hcfl_pkg::OFF_CTRL: rdata_ff <= {29'h0, sine_drive, ctrl_ff};
                hcfl_pkg::OFF_ADV: rdata_ff <= {24'h0, adv_ff};
                default: rdata_ff <= 32'h0;
            endcase
        end
    end
    assign prdata = rdata_ff;
    assign pready = 1'b1;
    // access above the advance register, or any unaligned write, answers with an error
    assign pslverr = psel && penable && (paddr[1:0] != 2'h0 || paddr > hcfl_pkg::OFF_ADV)
                     && !rd_en ? 1'b1 : (rd_en && paddr > hcfl_pkg::OFF_ADV);
endmodule

// ---- verif/hcfl_tb_pkg.sv ----
package hcfl_tb_pkg;
    // expected {high u v w, low u v w} in trapezoidal drive
    function automatic logic [5:0] trap_cmd(input logic [2:0] h, input logic fwd);
        logic [2:0] k;
        k = fwd ? h : ~h; // reverse table is the forward one with halls inverted
        case (k)
            3'h5: trap_cmd = 6'h14;
            3'h4: trap_cmd = 6'h0C;
            3'h6: trap_cmd = 6'h0A;
            3'h2: trap_cmd = 6'h22;
            3'h3: trap_cmd = 6'h21;
            3'h1: trap_cmd = 6'h11;
            default: trap_cmd = 6'h00; // all equal: everything off
        endcase
    endfunction
    // one advance step toward target, landing when close
    function automatic logic [7:0] adv_step(input logic [7:0] c, input logic [7:0] t);
        if (c + hcfl_pkg::ADV_STEP_Q4 <= t) adv_step = c + hcfl_pkg::ADV_STEP_Q4;
        else if (t + hcfl_pkg::ADV_STEP_Q4 <= c) adv_step = c - hcfl_pkg::ADV_STEP_Q4;
        else adv_step = t;
    endfunction
endpackage

// ---- verif/hcfl_hall_model.sv ----
`timescale 1ns/10ps
// hall sensors: walk the six valid states, or show a raw pattern
module hcfl_hall_model (
    // clock
    input wire logic clock,
    // control
    input wire logic step,
    input wire logic fwd,
    input wire logic raw_en,
    input wire logic [2:0] raw,
    // sensor pins u v w
    output logic [2:0] hall
);
    // forward rotation order; never all equal
    localparam logic [2:0] ORD [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
    logic [2:0] pos_ff = 3'h0; // position in the order
    // one sixty degree move per step, either sense
    always_ff @(posedge clock) begin
        if (step && fwd) pos_ff <= (pos_ff == 3'h5) ? 3'h0 : pos_ff + 3'h1;
        else if (step) pos_ff <= (pos_ff == 3'h0) ? 3'h5 : pos_ff - 3'h1;
    end
    assign hall = raw_en ? raw : ORD[pos_ff];
endmodule

// ---- verif/hcfl_top_asserts.sv ----
`timescale 1ns/10ps
// switch and fault pins against hall and protection inputs
module hcfl_top_asserts #(
    parameter int unsigned OC_HOLD_CYCLES = 50
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // hall inputs
    input wire logic hall_u,
    input wire logic hall_v,
    input wire logic hall_w,
    // protection flags and settings
    input wire logic reference_undervoltage_lockout,
    input wire logic supply_undervoltage_lockout,
    input wire logic [2:0] bootstrap_undervoltage_lockout,
    input wire logic overcurrent_shutdown,
    input wire logic thermal_shutdown,
    input wire logic motor_lock_guard,
    input wire logic direction_select,
    // outputs watched
    input wire logic [2:0] high_side_on,
    input wire logic [2:0] low_side_on,
    input wire logic fault_out
);
    int unsigned oc_cnt_ff; // hold window left, plus sync margin
    logic oc_d_ff; // last raw overcurrent flag
    logic [5:0] sw; // all six commands
    assign sw = {high_side_on, low_side_on};
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // window starts at the raw rise; margins cover the filter lag
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            oc_cnt_ff <= 0;
            oc_d_ff <= 1'b0;
        end else begin
            oc_d_ff <= overcurrent_shutdown;
            if (overcurrent_shutdown && !oc_d_ff) oc_cnt_ff <= OC_HOLD_CYCLES + 8;
            else if (oc_cnt_ff != 0) oc_cnt_ff <= oc_cnt_ff - 1;
        end
    end
    // halls all equal long enough to pass the filter
    sequence s_hall_bad;
        (hall_u == hall_v && hall_v == hall_w) [*8];
    endsequence
    // no protection active, halls and direction steady
    sequence s_calm;
        (!reference_undervoltage_lockout && !supply_undervoltage_lockout
            && bootstrap_undervoltage_lockout == 3'h0 && !overcurrent_shutdown
            && oc_cnt_ff == 0 && !thermal_shutdown && !motor_lock_guard
            && $stable({hall_u, hall_v, hall_w, direction_select})) [*8];
    endsequence
    a_no_shoot: assert property ((high_side_on & low_side_on) == 3'h0)
        else $error("both switches of one phase on");
    a_ref_lock: assert property (
        reference_undervoltage_lockout [*8] |-> sw == 6'h00 && fault_out)
        else $error("reference lockout not obeyed");
    a_sup_lock: assert property (
        supply_undervoltage_lockout [*8] |-> sw == 6'h00)
        else $error("supply lockout not obeyed");
    a_boot_gate: assert property (
        (bootstrap_undervoltage_lockout != 3'h0 && $stable(bootstrap_undervoltage_lockout)) [*8]
        |-> (high_side_on & bootstrap_undervoltage_lockout) == 3'h0)
        else $error("high side on under bootstrap lockout");
    a_hall_bad: assert property (s_hall_bad |-> sw == 6'h00 && fault_out)
        else $error("bad hall state not handled");
    a_trip_fault: assert property (
        (thermal_shutdown || motor_lock_guard) [*8] |-> sw == 6'h00 && fault_out)
        else $error("thermal or lock trip not handled");
    a_oc_hold: assert property (
        oc_cnt_ff > 8 && oc_cnt_ff <= OC_HOLD_CYCLES |-> fault_out && sw == 6'h00)
        else $error("overcurrent hold too short");
    a_trap_table: assert property (
        s_calm |-> sw == hcfl_tb_pkg::trap_cmd({hall_u, hall_v, hall_w}, direction_select))
        else $error("switch commands differ from hall table");
endmodule
bind hcfl_top hcfl_top_asserts #(.OC_HOLD_CYCLES(OC_HOLD_CYCLES)) watch (
    .clock, .sys_rst, .hall_u, .hall_v, .hall_w,
    .reference_undervoltage_lockout, .supply_undervoltage_lockout,
    .bootstrap_undervoltage_lockout, .overcurrent_shutdown, .thermal_shutdown,
    .motor_lock_guard, .direction_select, .high_side_on, .low_side_on, .fault_out
);

// ---- verif/hcfl_top_bench.sv ----
`timescale 1ns/10ps
// self-checking bench for commutation and fault logic
module hcfl_top_bench;
    // clock, reset, bookkeeping
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    int n_mismatch = 0;
    int tests_run = 0;
    int seed = 12;
    // hall model control
    logic m_step = 1'b0;
    logic m_fwd = 1'b1;
    logic raw_en = 1'b0;
    logic [2:0] raw = 3'h1;
    logic [2:0] hall;
    // protections and settings
    logic uv_ref = 1'b0;
    logic uv_sup = 1'b0;
    logic [2:0] uv_boot = 3'h0;
    logic oc = 1'b0;
    logic hot = 1'b0;
    logic lock = 1'b0;
    logic fwd_sel = 1'b1;
    logic [7:0] lvl = 8'h00;
    // register bus
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    // outputs
    logic [2:0] hs, ls;
    logic fault, irq, sine;
    // scratch
    logic [31:0] q, r;
    logic e;
    logic [7:0] ea;
    hcfl_top #(.OC_HOLD_CYCLES(50), .SINE_PERIOD_CYCLES(200)) uut (
        .clock, .sys_rst, .hall_u(hall[2]), .hall_v(hall[1]), .hall_w(hall[0]),
        .reference_undervoltage_lockout(uv_ref), .supply_undervoltage_lockout(uv_sup),
        .bootstrap_undervoltage_lockout(uv_boot), .overcurrent_shutdown(oc),
        .thermal_shutdown(hot), .motor_lock_guard(lock), .direction_select(fwd_sel),
        .advance_level_input(lvl), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .high_side_on(hs), .low_side_on(ls), .fault_out(fault),
        .irq, .sine_drive(sine));
    hcfl_hall_model mdl (.clock, .step(m_step), .fwd(m_fwd), .raw_en, .raw, .hall);
    // 125 MHz
    initial begin
        forever #4 clock = ~clock;
    end
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask
    // one transfer and an idle edge, so the write has landed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) begin
            n_mismatch++; // no answer: cut the run short
            finish_test();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    // hall steps spaced so the filter settles
    task automatic steps(input int n);
        repeat (n) begin
            m_step <= 1'b1;
            @(posedge clock);
            m_step <= 1'b0;
            wt(20);
        end
    endtask
    function automatic logic [31:0] sw_exp();
        return {26'h0, hcfl_tb_pkg::trap_cmd(hall, fwd_sel)};
    endfunction
    initial begin
        wt(4);
        chk({24'h0, fault, irq, hs, ls}, 32'h0); // all quiet in reset
        sys_rst <= 1'b0;
        wt(10);
        apb(1'b0, hcfl_pkg::OFF_CTRL, 32'h0);
        chk(q, 32'h1);
        apb(1'b0, hcfl_pkg::OFF_MASK, 32'h0);
        chk(q, 32'h0);
        apb(1'b1, 8'h10, 32'hF);
        chk({31'h0, e}, 32'h1);
        // walk each direction in its own sense
        for (int d = 0; d < 2; d++) begin
            fwd_sel <= d[0];
            m_fwd <= d[0];
            for (int i = 0; i < 6; i++) begin
                steps(1);
                chk({hs, ls}, sw_exp());
                chk(fault, 1'b0);
            end
        end
        // random patterns and direction, bad states among them
        raw_en <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            raw <= (i < 2) ? {3{i[0]}} : r[2:0];
            fwd_sel <= r[3];
            wt(10);
            chk({hs, ls}, sw_exp());
            if (raw == 3'h0 || raw == 3'h7) chk(fault, 1'b1);
        end
        raw_en <= 1'b0;
        fwd_sel <= 1'b1;
        m_fwd <= 1'b1;
        steps(2);
        // each lockout and trip, then release
        for (int k = 0; k < 5; k++) begin
            r = $random(seed);
            uv_ref <= (k == 0);
            uv_sup <= (k == 1);
            uv_boot <= (k == 2) ? (r[2:0] | 3'h1) : 3'h0;
            hot <= (k == 3);
            lock <= (k == 4);
            wt(10);
            chk({hs, ls}, (k == 2) ? sw_exp() & {26'h0, ~uv_boot, 3'h7} : 32'h0);
            chk(fault, (k == 0 || k >= 3));
            {uv_ref, uv_sup, uv_boot, hot, lock} <= 7'h00;
            wt(10);
            chk({hs, ls}, sw_exp());
            chk(fault, 1'b0);
        end
        // overcurrent hold, with its interrupt raised, masked, cleared
        apb(1'b1, hcfl_pkg::OFF_MASK, 32'h1 << hcfl_pkg::EV_OVERCURRENT);
        oc <= 1'b1;
        wt(3);
        oc <= 1'b0;
        wt(30); // halls held still, as the host stops its inputs
        chk({fault, irq, hs, ls}, 32'hC0);
        wt(30);
        chk({fault, hs, ls}, sw_exp());
        apb(1'b1, hcfl_pkg::OFF_MASK, 32'h0);
        chk(irq, 1'b0);
        apb(1'b1, hcfl_pkg::OFF_MASK, 32'h1 << hcfl_pkg::EV_OVERCURRENT);
        chk(irq, 1'b1);
        apb(1'b1, hcfl_pkg::OFF_STATUS, 32'h1 << hcfl_pkg::EV_OVERCURRENT);
        apb(1'b0, hcfl_pkg::OFF_STATUS, 32'h0);
        chk({irq, q[2:0]}, 32'h3); // fault and bad-hall bits still set
        // advance stepping toward two random targets
        ea = 8'h00;
        for (int t = 3; t > 1; t--) begin
            r = $random(seed);
            lvl <= {2'h0, r[5:0]};
            @(posedge clock);
            repeat (t) ea = hcfl_tb_pkg::adv_step(ea, lvl);
            steps(24 * t); // four hall cycles per step
            apb(1'b0, hcfl_pkg::OFF_ADV, 32'h0);
            chk(q, {24'h0, ea});
        end
        apb(1'b0, hcfl_pkg::OFF_CTRL, 32'h0);
        chk({sine, q[30:0]}, 32'h8000_0005);
        m_fwd <= 1'b0;
        steps(1);
        chk({sine, fault}, 32'h1);
        m_fwd <= 1'b1;
        steps(1);
        chk(fault, 1'b0);
        apb(1'b1, hcfl_pkg::OFF_CTRL, 32'h3);
        wt(2);
        apb(1'b0, hcfl_pkg::OFF_ADV, 32'h0);
        chk(q, 32'h0);
        finish_test();
    end
endmodule
